// ===== sim/psk_rom_model.sv
// program rom model: async-read byte array answering in the same cycle.
// assumes the bench fills mem directly before the reset that starts each run.
`default_nettype none

// ************************************************************
// rom model
// ************************************************************
module psk_rom_model (
  input wire logic [11:0] i_addr,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:4095];
  // combinational read, no wait states
  assign o_data = mem[i_addr];
endmodule // psk_rom_model

`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the program sequencer and skip logic.
// assumes psk_pkg and psk_sequencer compiled first, rom model beside it.
`default_nettype none

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module testbench;
  import psk_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // signals and instances
  // ************************************************************
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  psk_core_s core = '0;
  logic [11:0] rom_addr;
  logic [7:0] rom_data;
  logic [7:0] latch;
  logic [7:0] last_latch = 8'h00;
  logic [11:0] pc;
  logic skip;
  logic nop;
  int nops = 0;
  int skips = 0;
  psk_lookup_s lookup;
  psk_call_s call;
  psk_exec_s exec;
  int errors = 0;
  int checks = 0;
  int idx = 0;
  int cyc = 0;
  bit arm = 1'b0;
  logic [31:0] q [$];

  psk_sequencer i_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_rom_data(rom_data), .i_core(core),
    .o_rom_addr(rom_addr), .o_pc(pc), .o_skip(skip), .o_forced_nop(nop), .o_table_latch(latch), .o_lookup(lookup),
    .o_call(call), .o_exec(exec));
  psk_rom_model i_rom (.i_addr(rom_addr), .o_data(rom_data));

  // clock and hang guard
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_of_test();
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // note: kind, slot index seen, value
  function automatic void ex(input logic [7:0] k, input int i, input logic [15:0] v);
    q.push_back({k, 8'(i), v});
  endfunction

  // rom byte, plus an exec note when the slot index is nonzero
  task automatic put(input logic [11:0] a, input logic [7:0] b, input int i);
    i_rom.mem[a] = b;
    // exec note carries the counter low byte: next address, or the return target 12'h040
    if (i > 0) ex(8'h01, i, {(b inside {PSK_OP_RET, PSK_OP_RETURN_AND_SKIP_OP}) ? 8'h40 : 8'(a + 12'h001), b});
  endtask

  task automatic clear_rom;
    for (int a = 0; a < 4096; a++) i_rom.mem[a] = 8'h44;
  endtask

  task automatic start(input psk_core_s c);
    @(posedge i_ref_clk);
    i_resetn <= 1'b0;
    core <= c;
    repeat (5) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    nops = 0;
    skips = 0;
    arm = 1'b1;
  endtask

  task automatic finish_run(input int exp_nop, input int exp_skip);
    int n;
    n = 0;
    while (q.size() != 0 && n < 100) begin
      @(posedge i_ref_clk);
      n++;
    end
    arm = 1'b0;
    `CHK("notes left", 32'd0, 32'(q.size()))
    `CHK("forced no-op cycles", exp_nop, nops)
    `CHK("skip cycles", exp_skip, skips)
  endtask

  task automatic note(input logic [7:0] k, input logic [15:0] v);
    logic [31:0] e;
    e = (q.size() != 0) ? q.pop_front() : 32'hffffffff;
    `CHK("result", e, {k, 8'(idx), v})
  endtask

  // monitor: compares each result against the oldest note
  always @(negedge i_ref_clk) begin
    if (!i_resetn) begin
      idx = 0;
    end else begin
      if (arm) begin
        if (exec.valid === 1'b1) note(8'h01, {pc[7:0], exec.opcode});
        if (nop === 1'b1) nops++;
        if (skip === 1'b1) skips++;
        if (latch !== last_latch) note(8'h04, {8'h00, latch});
        if (lookup.valid === 1'b1) note(8'h02, {8'h00, lookup.acc, lookup.ram});
        if (call.valid === 1'b1) note(8'h03, {4'h0, call.ret_addr});
      end
      idx++;
    end
    last_latch = latch;
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    psk_core_s c;
    logic [3:0] a;
    logic [3:0] r;
    logic [11:0] loc;
    logic [11:0] t;
    logic [11:0] d;
    logic [25:0] sk;
    logic [7:0] prog [26];
    void'($urandom(59102));
    // look-ups, long jump, call and chapter crossing
    a = 4'(1 + $urandom % 14);
    r = 4'($urandom % 16);
    c = '0;
    c.acc = a;
    c.ram = r;
    clear_rom();
    i_rom.mem[{4'h0, a, r}] = 8'h5a;
    i_rom.mem[{4'h1, a, r}] = 8'hc3;
    put(12'h000, PSK_OP_LOOKUP_TO_LATCH_OP, 1);
    ex(8'h04, 2, 16'h005a);
    put(12'h001, 8'h80, 3);
    put(12'h002, PSK_OP_LID, 4);
    i_rom.mem[12'h003] = 8'h00;
    ex(8'h02, 6, 16'h005a);
    put(12'h004, 8'h60, 7);
    i_rom.mem[12'h005] = 8'hff;
    put(12'h0ff, PSK_OP_LOOKUP_TO_LATCH_OP, 9);
    ex(8'h04, 10, 16'h00c3);
    put(12'h100, 8'h68, 11);
    i_rom.mem[12'h101] = 8'hf0;
    ex(8'h03, 12, 16'h0102);
    put(12'h0f0, 8'h67, 13);
    i_rom.mem[12'h0f1] = 8'hfe;
    put(12'h7fe, 8'h60, 15);
    i_rom.mem[12'h7ff] = 8'h40;
    put(12'h840, 8'h81, 17);
    start(c);
    finish_run(0, 0);
    // indirect jump destination table
    for (int i = 0; i < 4; i++) begin
      loc = i[1] ? 12'h1ff : 12'h150;
      a = i[0] ? 4'hf : 4'h3;
      r = i[0] ? 4'hf : 4'h4;
      t = {4'((loc + 12'h001) >> 8), a, r};
      d = {4'((t + 12'h001) >> 8), 8'h40};
      c = '0;
      c.acc = a;
      c.ram = r;
      clear_rom();
      put(12'h000, 8'h60 | {5'h00, loc[10:8]}, 1);
      i_rom.mem[12'h001] = loc[7:0];
      put(loc, PSK_OP_JID, 3);
      i_rom.mem[t] = 8'h40;
      put(d, 8'h90 + 8'(i), 5);
      start(c);
      finish_run(0, 0);
    end
    // skips: test, add, exchange, pointer-load chain, return-and-skip
    prog = '{8'h20, 8'h60, 8'h00, 8'h20, 8'hbf, 8'h20, 8'h33, 8'h00, 8'h82, 8'h30, 8'h81, 8'h10, 8'h83,
      8'h51, 8'h84, 8'h50, 8'h85, 8'h34, 8'h86, 8'h35, 8'h87, 8'h01, 8'h02, 8'h03, 8'h88, 8'h49};
    sk = 26'h0c444d6;
    c = '0;
    c.acc = 4'hf;
    c.ram = 4'h1;
    c.test_met = 1'b1;
    c.pointer_digit_field = 4'hf;
    c.ret_addr = 12'h040;
    clear_rom();
    for (int i = 0; i < 26; i++) begin
      put(12'(i), prog[i], sk[i] ? 0 : i + 1);
    end
    put(12'h040, 8'h89, 0);
    put(12'h041, 8'h8a, 28);
    // plain return comes back to 12'h040 and runs it this time
    put(12'h042, PSK_OP_RET, 29);
    ex(8'h01, 30, 16'h4189);
    start(c);
    // one no-op cycle per skipped byte, plus the one at 12'h040; skip slots: nine plus the chain's end
    finish_run($countones(sk) + 1, 10);
    end_of_test();
  end
endmodule // testbench

`default_nettype wire

// ===== src/psk_pkg.sv
// package for the program sequencer and skip logic: widths, opcode codes,
// states, operation classes and the carrier structs.
// assumes one instruction-cycle clock shared with the core and an async-read rom.
`default_nettype none

package psk_pkg;

  // ************************************************************
  // address space
  // ************************************************************
  localparam int unsigned PSK_PC_W = 12; // program counter width, two chapters
  localparam int unsigned PSK_BLOCK_LSB = 8; // block = 256 words (four 64-word pages)
  localparam int unsigned PSK_CHAPTER_LSB = 11; // chapter = 2048 words
  localparam logic [PSK_PC_W-1:0] PSK_RESET_PC = 12'h000;

  // ************************************************************
  // opcode codes (first byte) and match masks
  // ************************************************************
  localparam logic [7:0] PSK_OP_JID = 8'hff; // indirect_jump_op
  localparam logic [7:0] PSK_OP_LOOKUP_TO_LATCH_OP = 8'hbf; // lookup_to_latch_op
  localparam logic [7:0] PSK_OP_LID = 8'h33; // lookup_to_accumulator_op, two bytes
  localparam logic [7:0] PSK_OP_ASC = 8'h30; // add_carry_skip_op
  localparam logic [7:0] PSK_OP_COMPLEMENT_ADD_CARRY_SKIP_OP = 8'h10; // complement_add_carry_skip_op
  localparam logic [7:0] PSK_OP_XIS = 8'h34; // exchange_increment_skip_op
  localparam logic [7:0] PSK_OP_XDS = 8'h35; // exchange_decrement_skip_op
  localparam logic [7:0] PSK_OP_RET = 8'h48; // plain return
  localparam logic [7:0] PSK_OP_RETURN_AND_SKIP_OP = 8'h49; // return_and_skip_op
  localparam logic [7:0] PSK_MASK_LONG = 8'hf8; // long jump/call, low 3 bits = addr 10:8
  localparam logic [7:0] PSK_VAL_JMP = 8'h60; // long_jump_op
  localparam logic [7:0] PSK_VAL_JSR = 8'h68; // long_call_op
  localparam logic [7:0] PSK_MASK_NIB = 8'hf0;
  localparam logic [7:0] PSK_VAL_ADD_IMMEDIATE_SKIP_OP = 8'h50; // add_immediate_skip_op, low nibble = imm
  localparam logic [7:0] PSK_VAL_LBI = 8'h00; // load_pointer_immediate_op
  localparam logic [7:0] PSK_MASK_TEST = 8'hfc;
  localparam logic [7:0] PSK_VAL_TEST = 8'h20; // test ops, condition from core
  localparam logic [3:0] PSK_NIB_MAX = 4'hf;
  localparam logic [3:0] PSK_NIB_MIN = 4'h0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    S_OP = 4'b0001,
    S_SECOND = 4'b0010,
    S_TABLE = 4'b0100,
    S_SKIP2 = 4'b1000
  } psk_state_e;

  typedef enum logic [3:0] {
    C_OTHER, C_JID, C_LOOKUP_TO_LATCH_OP, C_LID, C_JMP, C_JSR, C_ASC, C_COMPLEMENT_ADD_CARRY_SKIP_OP,
    C_ADD_IMMEDIATE_SKIP_OP, C_LBI, C_XIS, C_XDS, C_RET, C_RETURN_AND_SKIP_OP, C_TEST
  } psk_op_e;

  typedef struct packed {
    logic [3:0] acc; // accumulator
    logic [3:0] ram; // ram word at pointer
    logic carry; // carry register
    logic [3:0] pointer_digit_field; // value before exchange
    logic test_met; // condition of a test op
    logic [PSK_PC_W-1:0] ret_addr; // top of subroutine stack
  } psk_core_s;

  typedef struct packed {
    logic valid;
    logic [3:0] acc;
    logic [3:0] ram;
  } psk_lookup_s;

  typedef struct packed {
    logic valid;
    logic [PSK_PC_W-1:0] ret_addr;
  } psk_call_s;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
  } psk_exec_s;

endpackage

`default_nettype wire

// ===== src/psk_sequencer.sv
// program counter sequencing, indirect look-ups, long jumps and skip control.
// assumes an async-read rom answering o_rom_addr in the same cycle, and a core
// on the same clock supplying accumulator, ram word, pointer digit and stack top.
`default_nettype none

// Contract
// - table look-up replaces low eight pc bits
// - latch look-up to latch, other to acc/ram
// - look-up at block end reads next block
// - indirect jump loads only low eight bits
// - jump block: N, N+1, or N+2
// - long jump/call within chapter, end crosses
// - met test suppresses next instruction
// - skipped instruction becomes byte-length no-op
// - indirect ops one cycle longer unless skipped
// - add ops skip on four-bit carry
// - pointer-load chain skips following pointer-loads
// - exchange ops skip on digit wrap
// - return-and-skip skips instruction at return
// - block is 256 words, bits above eight
module psk_sequencer (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_rom_data,
  input wire psk_pkg::psk_core_s i_core,
  output logic [psk_pkg::PSK_PC_W-1:0] o_rom_addr,
  output logic [psk_pkg::PSK_PC_W-1:0] o_pc,
  output logic o_skip,
  output logic o_forced_nop,
  output logic [7:0] o_table_latch,
  output psk_pkg::psk_lookup_s o_lookup,
  output psk_pkg::psk_call_s o_call,
  output psk_pkg::psk_exec_s o_exec
);
  import psk_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************

  // opcode class from the first byte
  function automatic psk_op_e decode(input logic [7:0] op);
    psk_op_e c;
    c = C_OTHER;
    if (op == PSK_OP_JID) c = C_JID;
    else if (op == PSK_OP_LOOKUP_TO_LATCH_OP) c = C_LOOKUP_TO_LATCH_OP;
    else if (op == PSK_OP_LID) c = C_LID;
    else if (op == PSK_OP_ASC) c = C_ASC;
    else if (op == PSK_OP_COMPLEMENT_ADD_CARRY_SKIP_OP) c = C_COMPLEMENT_ADD_CARRY_SKIP_OP;
    else if (op == PSK_OP_XIS) c = C_XIS;
    else if (op == PSK_OP_XDS) c = C_XDS;
    else if (op == PSK_OP_RET) c = C_RET;
    else if (op == PSK_OP_RETURN_AND_SKIP_OP) c = C_RETURN_AND_SKIP_OP;
    else if ((op & PSK_MASK_LONG) == PSK_VAL_JMP) c = C_JMP;
    else if ((op & PSK_MASK_LONG) == PSK_VAL_JSR) c = C_JSR;
    else if ((op & PSK_MASK_NIB) == PSK_VAL_ADD_IMMEDIATE_SKIP_OP) c = C_ADD_IMMEDIATE_SKIP_OP;
    else if ((op & PSK_MASK_NIB) == PSK_VAL_LBI) c = C_LBI;
    else if ((op & PSK_MASK_TEST) == PSK_VAL_TEST) c = C_TEST;
    return c;
  endfunction

  // two-byte opcodes
  function automatic logic two_bytes(input psk_op_e c);
    return (c == C_LID) || (c == C_JMP) || (c == C_JSR);
  endfunction

  // carry out of a four-bit binary add
  function automatic logic carry4(input logic [3:0] a, input logic [3:0] b, input logic cin);
    logic [4:0] sum;
    sum = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    return sum[4];
  endfunction

  // block number of an address
  function automatic logic [PSK_PC_W-PSK_BLOCK_LSB-1:0] block_of(input logic [PSK_PC_W-1:0] a);
    return a[PSK_PC_W-1:PSK_BLOCK_LSB];
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  psk_state_e state;
  psk_state_e next_state;
  psk_op_e op_hold;
  logic [2:0] long_hi;
  logic [PSK_PC_W-1:0] pc;
  logic [PSK_PC_W-1:0] rom_addr;
  logic [PSK_PC_W-1:0] next_pc;
  logic [PSK_PC_W-1:0] next_rom;
  logic skip_pend;
  logic skip_lbi;
  logic next_skip;

  psk_op_e cls;
  logic executing;
  logic skipping;
  logic [PSK_PC_W-1:0] pc_inc;
  logic [PSK_PC_W-1:0] tbl_inc;
  logic [PSK_PC_W-1:0] table_addr;

  assign cls = decode(i_rom_data);
  // a pointer-load skip only hits a further pointer-load, the first other op runs
  assign skipping = skip_pend && (!skip_lbi || (cls == C_LBI));
  assign executing = (state == S_OP) && !skipping;
  assign pc_inc = pc + 12'h001; // counter advances before execution
  assign tbl_inc = rom_addr + 12'h001;
  // table address keeps pc bits above the low eight of the advanced pc
  assign table_addr = {pc_inc[PSK_PC_W-1:PSK_BLOCK_LSB], i_core.acc, i_core.ram};

  assign o_rom_addr = rom_addr;
  assign o_pc = pc;
  assign o_skip = skip_pend;
  // slot currently replaced by a hardware no-op
  assign o_forced_nop = (skipping && (state == S_OP)) || (state == S_SKIP2);

  // ************************************************************
  // sequencing
  // ************************************************************

  // next state, counter and rom address
  always_comb begin
    next_state = S_OP;
    next_pc = pc_inc;
    next_rom = pc_inc;
    unique case (state)
      S_OP: begin
        if (skipping) begin
          if (two_bytes(cls)) next_state = S_SKIP2;
        end else begin
          unique case (cls)
            C_JID, C_LOOKUP_TO_LATCH_OP: begin
              next_rom = table_addr;
              next_state = S_TABLE;
            end
            C_LID, C_JMP, C_JSR: next_state = S_SECOND;
            C_RET, C_RETURN_AND_SKIP_OP: begin
              next_pc = i_core.ret_addr;
              next_rom = i_core.ret_addr;
            end
            default: ;
          endcase
        end
      end
      S_SECOND: begin
        if (op_hold == C_LID) begin
          next_rom = table_addr;
          next_state = S_TABLE;
        end else begin
          // chapter from the advanced counter, rest from the two bytes
          next_pc = {pc_inc[PSK_PC_W-1:PSK_CHAPTER_LSB], long_hi, i_rom_data};
          next_rom = next_pc;
        end
      end
      S_TABLE: begin
        next_pc = pc;
        next_rom = pc;
        if (op_hold == C_JID) begin
          // block follows the table address plus one
          next_pc = {tbl_inc[PSK_PC_W-1:PSK_BLOCK_LSB], i_rom_data};
          next_rom = next_pc;
        end
      end
      S_SKIP2: ;
    endcase
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) state <= S_OP;
    else state <= next_state;
  end

  // program counter and rom address
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc <= PSK_RESET_PC;
      rom_addr <= PSK_RESET_PC;
    end else begin
      pc <= next_pc;
      rom_addr <= next_rom;
    end
  end

  // opcode held across multi-cycle ops
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      op_hold <= C_OTHER;
      long_hi <= 3'h0;
    end else if (state == S_OP) begin
      op_hold <= cls;
      long_hi <= i_rom_data[2:0];
    end
  end

  // ************************************************************
  // skip generation
  // ************************************************************

  // skip condition of the instruction executing now
  always_comb begin
    next_skip = 1'b0;
    unique case (cls)
      C_TEST: next_skip = i_core.test_met;
      C_ASC: next_skip = carry4(i_core.acc, i_core.ram, i_core.carry);
      C_COMPLEMENT_ADD_CARRY_SKIP_OP: next_skip = carry4(~i_core.acc, i_core.ram, i_core.carry);
      C_ADD_IMMEDIATE_SKIP_OP: next_skip = carry4(i_core.acc, i_rom_data[3:0], 1'b0);
      C_LBI: next_skip = 1'b1;
      C_XIS: next_skip = (i_core.pointer_digit_field == PSK_NIB_MAX);
      C_XDS: next_skip = (i_core.pointer_digit_field == PSK_NIB_MIN);
      C_RETURN_AND_SKIP_OP: next_skip = 1'b1;
      default: next_skip = 1'b0;
    endcase
  end

  // pending skip, consumed by one opcode slot
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      skip_pend <= 1'b0;
      skip_lbi <= 1'b0;
    end else if (state == S_OP) begin
      if (skipping) begin
        skip_pend <= skip_lbi && (cls == C_LBI);
        skip_lbi <= skip_lbi && (cls == C_LBI);
      end else begin
        skip_pend <= next_skip;
        skip_lbi <= (cls == C_LBI);
      end
    end
  end

  // ************************************************************
  // results toward the core
  // ************************************************************

  // table word into the lookup latch
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) o_table_latch <= 8'h00;
    else if ((state == S_TABLE) && (op_hold == C_LOOKUP_TO_LATCH_OP)) o_table_latch <= i_rom_data;
  end

  // table word back to accumulator and ram
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) o_lookup <= '0;
    else begin
      o_lookup.valid <= (state == S_TABLE) && (op_hold == C_LID);
      o_lookup.acc <= i_rom_data[7:4];
      o_lookup.ram <= i_rom_data[3:0];
    end
  end

  // return address push for the long call
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) o_call <= '0;
    else begin
      o_call.valid <= (state == S_SECOND) && (op_hold == C_JSR);
      o_call.ret_addr <= pc_inc;
    end
  end

  // executed opcode, one pulse per instruction start
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) o_exec <= '0;
    else begin
      o_exec.valid <= executing;
      o_exec.opcode <= i_rom_data;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_table_addr_low: assert property (
    (executing && ((cls == C_JID) || (cls == C_LOOKUP_TO_LATCH_OP))) |=>
      (state == S_TABLE) && (o_rom_addr[7:0] == {$past(i_core.acc), $past(i_core.ram)}) &&
      (block_of(o_rom_addr) == block_of($past(pc_inc))))
    else $error("table address not formed from acc and ram");

  a_lid_result: assert property (
    (executing && (cls == C_LID)) |=> ##2
      (o_lookup.valid && ({o_lookup.acc, o_lookup.ram} == $past(i_rom_data))))
    else $error("lookup result not returned to acc and ram");

  a_lid_block_end: assert property (
    (executing && (cls == C_LID)) |=> ##1
      (block_of(o_rom_addr) == block_of($past(pc, 2) + 12'h002)))
    else $error("lookup at block end not in next block");

  a_jid_dest: assert property (
    ((state == S_TABLE) && (op_hold == C_JID)) |=>
      (o_pc[7:0] == $past(i_rom_data)) && (block_of(o_pc) ==
        block_of($past(rom_addr)) + {3'h0, ($past(rom_addr[7:0]) == 8'hff)}))
    else $error("indirect jump destination wrong");

  a_long_target: assert property (
    ((state == S_SECOND) && (op_hold inside {C_JMP, C_JSR})) |=>
      (o_pc[7:0] == $past(i_rom_data)) && (o_pc[10:8] == $past(long_hi)) &&
      (o_pc[11] == $past(pc_inc[11])))
    else $error("long jump target wrong");

  a_skip_one_slot: assert property (
    (skip_pend && !skip_lbi && (state == S_OP)) |=> !skip_pend)
    else $error("skip held beyond one slot");

  a_chain_end: assert property (
    (skip_pend && skip_lbi && (state == S_OP) && (cls != C_LBI)) |-> !o_forced_nop)
    else $error("op after pointer-load chain was skipped");

  a_skip_length: assert property (
    (o_forced_nop && (state == S_OP) && two_bytes(cls)) |=> (state == S_SKIP2) ##1 (state == S_OP))
    else $error("skipped two-byte op wrong length");

  a_lid_cycles: assert property (
    (executing && (cls == C_LID)) |=> (state == S_SECOND) ##1 (state == S_TABLE) ##1 (state == S_OP))
    else $error("lookup-to-accumulator not three cycles");

  a_add_skip: assert property (
    (executing && (cls == C_ADD_IMMEDIATE_SKIP_OP) && (({1'b0, i_core.acc} + {1'b0, i_rom_data[3:0]}) > 5'd15)) |=> skip_pend)
    else $error("add immediate carry did not skip");

  a_lbi_chain: assert property (
    (skip_pend && skip_lbi && (state == S_OP) && (cls == C_LBI)) |=> skip_pend)
    else $error("pointer-load chain not skipped");

  a_digit_wrap: assert property (
    (executing && (((cls == C_XIS) && (i_core.pointer_digit_field == 4'hf)) ||
      ((cls == C_XDS) && (i_core.pointer_digit_field == 4'h0)))) |=> skip_pend)
    else $error("digit wrap did not skip");

  a_return_and_skip_op_skip: assert property (
    (executing && (cls == C_RETURN_AND_SKIP_OP)) |=> skip_pend && (o_pc == $past(i_core.ret_addr)))
    else $error("return-and-skip missed skip");

endmodule // psk_sequencer

`default_nettype wire
